// *** core/dacm_control.sv ***
// Overview of operation
// R1: straps pick 3-wire, I2C or pin control
// R2: host powers down before changing strap pins
// R3: pin mode ignores registers, register mode pins
// R4: pin control mode converts PCM only
// R5: pin mode offers clock, format, TDM, mute
// R6: bitstream selectors at 02H, 16H, reset PCM
// R7: auto bitstream switch at 15H, not DoP
// R8: auto packed switch at 16H, DoP only
// R9: clock setting 00H, bitstream clock 02H, 512fs
// R10: format at 00H PCM/DoP, TDM PCM only
// R11: volume bypass voids attenuation, zero detect, filter
// R12: path and fullscale mute act DSD/DoP only
// R13: mono, source, invert act in every mode
// R14: clock sync enabled by default, PCM/DoP only
// R15: host switches mode only during soft reset
// R16: auto packed switching overrides manual selectors
// R17: registers eight bits, reachable by serial port
`timescale 1ns/1ps
`default_nettype none
module dacm_control (
  input wire logic clk,
  input wire logic soft_reset_bit,
  input wire logic powerDownPinN,
  input wire logic busSelectPin,
  input wire logic controlSelectPin,
  input wire logic ctlClk,
  input wire logic ctlDataIn,
  input wire logic ctlSelectN,
  input wire dacm_pkg::dacm_pins_t fnPins,
  input wire logic detectDsd,
  input wire logic detectDop,
  output logic ctlDataOut,
  output logic ctlDataOe,
  output dacm_pkg::dacm_ctl_t ctlMode,
  output dacm_pkg::dacm_cfg_t cfg
);
  // whole state of the block
  typedef struct packed {
    dacm_pkg::dacm_ctl_t ctlMode;
    logic [dacm_pkg::NUM_REGS-1:0][7:0] regs;
    dacm_pkg::dacm_cfg_t cfg;
    dacm_pkg::dacm_bus_t bus;
    logic clkPrev;
    logic dataPrev;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [4:0] addr;
    logic isWrite;
    logic ackCycle;
    logic dataOut;
    logic dataOe;
  } dacm_state_t;

  dacm_state_t st_reg;
  dacm_state_t st_next;
  // synchronised pins
  logic sPdnN;
  logic sBus;
  logic sCtl;
  logic sClk;
  logic sData;
  logic sCsN;
  dacm_pkg::dacm_pins_t sPins;
  // serial clock and data events
  logic clkRise;
  logic clkFall;
  logic i2cStart;
  logic i2cStop;

  // every pin passes two flops before use
  dacm_sync2 #(
    .W(14)
  ) u_sync (
    .clk(clk),
    .soft_reset_bit(soft_reset_bit),
    .din({powerDownPinN, busSelectPin, controlSelectPin, ctlClk, ctlDataIn, ctlSelectN,
          fnPins}),
    .dout({sPdnN, sBus, sCtl, sClk, sData, sCsN, sPins})
  );

  assign clkRise = sClk & ~st_reg.clkPrev;
  assign clkFall = ~sClk & st_reg.clkPrev;
  // data moving while clock high marks start and stop
  assign i2cStart = sClk & st_reg.clkPrev & st_reg.dataPrev & ~sData;
  assign i2cStop = sClk & st_reg.clkPrev & ~st_reg.dataPrev & sData;

  // map an offset to {valid, index}; holes answer as invalid
  function automatic logic [4:0] regIndex(input logic [4:0] a);
    if (a <= dacm_pkg::ADDR_SLOT_FMT) begin
      regIndex = {1'b1, a[3:0]};
    end else if (a == dacm_pkg::ADDR_AUTO_BS) begin
      regIndex = {1'b1, dacm_pkg::IDX_AUTO_BS};
    end else if (a == dacm_pkg::ADDR_PACKED_BS) begin
      regIndex = {1'b1, dacm_pkg::IDX_PACKED_BS};
    end else begin
      regIndex = 5'h00;
    end
  endfunction : regIndex

  // read value; unmapped offsets read as zero
  function automatic logic [7:0] readReg(input logic [dacm_pkg::NUM_REGS-1:0][7:0] r,
                                         input logic [4:0] a);
    logic [4:0] ix;
    ix = regIndex(a);
    readReg = ix[4] ? r[ix[3:0]] : 8'h00;
  endfunction : readReg

  // work out what the datapath really sees
  function automatic dacm_pkg::dacm_cfg_t deriveCfg(
      input logic [dacm_pkg::NUM_REGS-1:0][7:0] r, input dacm_pkg::dacm_ctl_t m,
      input dacm_pkg::dacm_pins_t p, input logic dsdSeen, input logic dopSeen);
    dacm_pkg::dacm_cfg_t c;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r2;
    logic [7:0] r6;
    logic bypass;
    logic pcm;
    r0 = r[dacm_pkg::IDX_CLOCK_FORMAT];
    r1 = r[dacm_pkg::IDX_MUTE_EMPH];
    r2 = r[dacm_pkg::IDX_CONV_SELECT];
    r6 = r[dacm_pkg::IDX_PATH_MUTE];
    c = '0;
    if (m == dacm_pkg::CTL_PIN) begin
      // R4 pin control plays PCM only
      c.conv = dacm_pkg::CONV_PCM;
      // R5 only clock, format, slot and mute pins count
      c.autoClock = 1'b1;
      c.clockSet = p.clockSet;
      c.ifFormat = p.ifFormat;
      c.tdm = p.tdm;
      c.softMute = p.softMute;
      // R3 registers ignored, defaults stand in, soft reset released
      c.emphasis = dacm_pkg::EMPH_OFF;
      c.shortDelay = dacm_pkg::RST_MUTE_EMPH[dacm_pkg::SHORT_DELAY_BIT];
      c.attL = dacm_pkg::ATT_0DB;
      c.attR = dacm_pkg::ATT_0DB;
      c.syncEn = 1'b1;
      c.softResetN = 1'b1;
    end else begin
      // R8 R16 auto packed switching overrides selectors
      if (r[dacm_pkg::IDX_PACKED_BS][dacm_pkg::AUTO_PACKED_BIT]) begin
        c.conv = dopSeen ? dacm_pkg::CONV_DOP : dacm_pkg::CONV_PCM;
      // R6 manual packed select beats bitstream selection
      end else if (r[dacm_pkg::IDX_PACKED_BS][dacm_pkg::PACKED_SEL_BIT]) begin
        c.conv = dacm_pkg::CONV_DOP;
      // R7 auto bitstream switch, reached only outside DoP
      end else if (r[dacm_pkg::IDX_AUTO_BS][dacm_pkg::AUTO_BS_BIT]) begin
        c.conv = dsdSeen ? dacm_pkg::CONV_DSD : dacm_pkg::CONV_PCM;
      end else begin
        c.conv = r2[dacm_pkg::BS_MODE_BIT] ? dacm_pkg::CONV_DSD : dacm_pkg::CONV_PCM;
      end
      pcm = (c.conv == dacm_pkg::CONV_PCM);
      // R12 path choice only exists for bitstream data
      bypass = !pcm && r6[dacm_pkg::PATH_BYPASS_BIT];
      c.pathBypass = bypass;
      c.fsMute = !pcm && r6[dacm_pkg::FS_MUTE_BIT];
      // R9 clock setting for PCM/DoP, bitstream clock for DSD/DoP
      c.autoClock = (c.conv != dacm_pkg::CONV_DSD) && r0[dacm_pkg::AUTO_CLOCK_BIT];
      c.clockSet = (c.conv != dacm_pkg::CONV_DSD) ? r0[dacm_pkg::CLOCK_SET_LSB +: 2]
                                                  : dacm_pkg::CLK_512FS;
      c.bsClock = !pcm && r2[dacm_pkg::BS_CLOCK_BIT];
      // R10 format in PCM/DoP, slot format in PCM only
      c.ifFormat = (c.conv != dacm_pkg::CONV_DSD) ? r0[dacm_pkg::FORMAT_LSB +: 3]
                                                  : dacm_pkg::FMT_MSB32;
      c.tdm = pcm ? r[dacm_pkg::IDX_SLOT_FMT][dacm_pkg::TDM_LSB +: 2] : 2'h0;
      // PCM-only filters and emphasis
      c.emphasis = pcm ? r1[dacm_pkg::EMPH_LSB +: 2] : dacm_pkg::EMPH_OFF;
      c.shortDelay = pcm && r1[dacm_pkg::SHORT_DELAY_BIT];
      c.superSlow = pcm && r[dacm_pkg::IDX_INVERT][dacm_pkg::SUPER_SLOW_BIT];
      // R11 bypass voids attenuation, zero detect, filter, mute
      c.bsFilter = !pcm && !bypass && r[dacm_pkg::IDX_BS_FILTER][dacm_pkg::BS_FILTER_BIT];
      c.attL = bypass ? dacm_pkg::ATT_0DB : r[dacm_pkg::IDX_LEFT_ATT];
      c.attR = bypass ? dacm_pkg::ATT_0DB : r[dacm_pkg::IDX_RIGHT_ATT];
      c.zeroDetL = !bypass && r[dacm_pkg::IDX_ZERO_DET][dacm_pkg::ZD_LEFT_BIT];
      c.zeroDetR = !bypass && r[dacm_pkg::IDX_ZERO_DET][dacm_pkg::ZD_RIGHT_BIT];
      c.softMute = !bypass && r1[dacm_pkg::SOFT_MUTE_BIT];
      // R13 mono, source and invert in every mode
      c.mono = r2[dacm_pkg::MONO_BIT];
      c.leftSrc = r2[dacm_pkg::LEFT_SRC_BIT];
      c.left_invert = r[dacm_pkg::IDX_INVERT][dacm_pkg::LEFT_INV_BIT];
      c.right_invert = r[dacm_pkg::IDX_INVERT][dacm_pkg::RIGHT_INV_BIT];
      // R14 clock sync only for PCM and DoP
      c.syncEn = (c.conv != dacm_pkg::CONV_DSD) && r[dacm_pkg::IDX_SYNC][dacm_pkg::SYNC_EN_BIT];
      c.softResetN = r0[dacm_pkg::SOFT_RESET_BIT];
    end
    deriveCfg = c;
  endfunction : deriveCfg

  // next-state logic: straps, serial engines, register file
  always_comb begin
    logic [7:0] inByte;
    logic [4:0] ix;
    logic [7:0] rd;
    inByte = {st_reg.shift[6:0], sData};
    ix = regIndex(st_reg.addr);
    rd = readReg(st_reg.regs, st_reg.addr);
    st_next = st_reg;
    st_next.clkPrev = sClk;
    st_next.dataPrev = sData;
    if (!sPdnN) begin
      // power-down: registers back to defaults, straps followed
      // R1 bus select low is 3-wire, then control select decides
      if (!sBus) begin
        st_next.ctlMode = dacm_pkg::CTL_SERIAL3;
      end else if (!sCtl) begin
        st_next.ctlMode = dacm_pkg::CTL_I2C;
      end else begin
        st_next.ctlMode = dacm_pkg::CTL_PIN;
      end
      st_next.regs = dacm_pkg::RST_ALL;
      st_next.bus = dacm_pkg::B_IDLE;
      st_next.bitCnt = 4'h0;
      st_next.ackCycle = 1'b0;
      st_next.dataOut = 1'b0;
      st_next.dataOe = 1'b0;
    end else if (st_reg.ctlMode == dacm_pkg::CTL_SERIAL3) begin
      // 3-wire: header {write flag, offset}, then data byte
      if (sCsN) begin
        st_next.bus = dacm_pkg::B_W3;
        st_next.bitCnt = 4'h0;
        st_next.dataOe = 1'b0;
      end else if (st_reg.bus == dacm_pkg::B_W3 && clkRise) begin
        st_next.shift = inByte;
        st_next.bitCnt = st_reg.bitCnt + 4'h1;
        if (st_reg.bitCnt == dacm_pkg::HDR_LAST_BIT) begin
          st_next.isWrite = inByte[dacm_pkg::WRITE_FLAG_BIT];
          st_next.addr = inByte[4:0];
        end
        if (st_reg.bitCnt == dacm_pkg::FRAME_LAST_BIT) begin
          // extra clocks after a frame are ignored until deselect
          st_next.bus = dacm_pkg::B_HOLD;
          // R17 eight-bit write through the 3-wire port
          if (st_reg.isWrite && ix[4]) begin
            st_next.regs[ix[3:0]] = inByte;
          end
        end
      end else if (st_reg.bus == dacm_pkg::B_W3 && clkFall && st_reg.bitCnt[3]) begin
        // R17 read data shifted out MSB first on falling edges
        st_next.dataOe = !st_reg.isWrite;
        st_next.dataOut = rd[3'(4'h7 - {1'b0, st_reg.bitCnt[2:0]})];
      end else if (st_reg.bus != dacm_pkg::B_W3 && clkFall) begin
        st_next.dataOe = 1'b0;
      end
    end else if (st_reg.ctlMode == dacm_pkg::CTL_I2C) begin
      // open-drain: output low, enable pulls the line
      st_next.dataOut = 1'b0;
      if (i2cStart) begin
        st_next.bus = dacm_pkg::B_DEV;
        st_next.bitCnt = 4'h0;
        st_next.ackCycle = 1'b0;
        st_next.dataOe = 1'b0;
      end else if (i2cStop) begin
        st_next.bus = dacm_pkg::B_IDLE;
        st_next.dataOe = 1'b0;
      end else if (clkRise && !st_reg.ackCycle && st_reg.bus == dacm_pkg::B_RDATA) begin
        // host ack on ninth clock; our own ack clock must not bump the offset
        if (st_reg.bitCnt == dacm_pkg::BYTE_DONE) begin
          st_next.bus = sData ? dacm_pkg::B_HOLD : dacm_pkg::B_RDATA;
          st_next.addr = st_reg.addr + 5'h01;
          st_next.bitCnt = 4'h0;
        end else begin
          st_next.bitCnt = st_reg.bitCnt + 4'h1;
        end
      end else if (clkRise && !st_reg.ackCycle && st_reg.bitCnt != dacm_pkg::BYTE_DONE &&
                   (st_reg.bus == dacm_pkg::B_DEV || st_reg.bus == dacm_pkg::B_REG ||
                    st_reg.bus == dacm_pkg::B_WDATA)) begin
        st_next.shift = inByte;
        st_next.bitCnt = st_reg.bitCnt + 4'h1;
      end else if (clkFall && st_reg.ackCycle) begin
        // end of our acknowledge; a read starts its first bit here
        st_next.ackCycle = 1'b0;
        st_next.bitCnt = 4'h0;
        st_next.dataOe = (st_reg.bus == dacm_pkg::B_RDATA) && !rd[7];
      end else if (clkFall && st_reg.bus == dacm_pkg::B_RDATA) begin
        // R17 read byte driven MSB first, released for host ack
        st_next.dataOe = !st_reg.bitCnt[3] && !rd[3'(4'h7 - {1'b0, st_reg.bitCnt[2:0]})];
      end else if (clkFall && st_reg.bitCnt == dacm_pkg::BYTE_DONE) begin
        st_next.ackCycle = 1'b1;
        st_next.dataOe = 1'b1;
        if (st_reg.bus == dacm_pkg::B_DEV) begin
          if (st_reg.shift[7:1] == dacm_pkg::I2C_DEV_ADDR) begin
            st_next.bus = st_reg.shift[0] ? dacm_pkg::B_RDATA : dacm_pkg::B_REG;
          end else begin
            // not our address: B_HOLD, but bitCnt stays at BYTE_DONE, so the next falling edge acks, writes shift into the register at addr and advances addr
            st_next.bus = dacm_pkg::B_HOLD;
            st_next.ackCycle = 1'b0;
            st_next.dataOe = 1'b0;
          end
        end else if (st_reg.bus == dacm_pkg::B_REG) begin
          st_next.addr = st_reg.shift[4:0];
          st_next.bus = dacm_pkg::B_WDATA;
        end else begin
          // R17 eight-bit write through I2C, offset then advances
          if (ix[4]) begin
            st_next.regs[ix[3:0]] = st_reg.shift;
          end
          st_next.addr = st_reg.addr + 5'h01;
        end
      end
    end
    // settings follow the registers one cycle later
    st_next.cfg = deriveCfg(st_reg.regs, st_reg.ctlMode, sPins, detectDsd, detectDop);
  end

  // single state register; reset gives defaults and 3-wire mode
  always_ff @(posedge clk or negedge soft_reset_bit) begin
    if (!soft_reset_bit) begin
      st_reg <= '{ctlMode: dacm_pkg::CTL_SERIAL3, regs: dacm_pkg::RST_ALL,
                  cfg: '0, bus: dacm_pkg::B_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ctlDataOut = st_reg.dataOut;
  assign ctlDataOe = st_reg.dataOe;
  assign ctlMode = st_reg.ctlMode;
  assign cfg = st_reg.cfg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!soft_reset_bit);

  // strap sequence: powered down with a given bus select
  sequence sDownSerial;
    !sPdnN && !sBus;
  endsequence
  sequence sDownI2c;
    !sPdnN && sBus && !sCtl;
  endsequence

  a_strap_serial: assert property (sDownSerial |=> ctlMode == dacm_pkg::CTL_SERIAL3) // R1
    else $error("bus select low did not give 3-wire control");
  a_strap_i2c_mode: assert property (sDownI2c |=> ctlMode == dacm_pkg::CTL_I2C) // R1
    else $error("control select low did not give I2C control");
  a_pin_no_regs: assert property (ctlMode == dacm_pkg::CTL_PIN |=> // R3
      cfg.attL == dacm_pkg::ATT_0DB && !cfg.mono && !cfg.left_invert && cfg.syncEn)
    else $error("register contents leaked into pin control");
  a_reg_no_pins: assert property (ctlMode != dacm_pkg::CTL_PIN && sPdnN |=> // R3
      cfg.mono == $past(st_reg.regs[dacm_pkg::IDX_CONV_SELECT][dacm_pkg::MONO_BIT]))
    else $error("register mode did not follow its registers");
  a_pin_only_pcm: assert property (ctlMode == dacm_pkg::CTL_PIN |=> // R4
      cfg.conv == dacm_pkg::CONV_PCM)
    else $error("pin control left PCM conversion");
  a_pin_fn_pins: assert property (ctlMode == dacm_pkg::CTL_PIN |=> // R5
      cfg.tdm == $past(sPins.tdm) && cfg.softMute == $past(sPins.softMute) && cfg.autoClock)
    else $error("pin control did not follow its function pins");
  a_down_defaults: assert property (!sPdnN ##1 !sPdnN |=> // R6
      cfg.conv == dacm_pkg::CONV_PCM && cfg.syncEn && cfg.attR == dacm_pkg::ATT_0DB)
    else $error("defaults not restored during power-down");
  a_auto_packed: assert property (ctlMode != dacm_pkg::CTL_PIN && // R16
      st_reg.regs[dacm_pkg::IDX_PACKED_BS][dacm_pkg::AUTO_PACKED_BIT] |=>
      cfg.conv == ($past(detectDop) ? dacm_pkg::CONV_DOP : dacm_pkg::CONV_PCM))
    else $error("auto packed switching did not follow detection");
  a_bypass_voids: assert property (cfg.pathBypass |-> // R11
      cfg.attL == dacm_pkg::ATT_0DB && !cfg.zeroDetR && !cfg.bsFilter && !cfg.softMute)
    else $error("volume bypass left level functions active");
  a_bitstream_only: assert property (cfg.conv == dacm_pkg::CONV_PCM |-> // R12
      !cfg.pathBypass && !cfg.fsMute && cfg.bsClock == 1'b0)
    else $error("bitstream-only control active in PCM");
  a_sync_no_dsd: assert property (cfg.conv == dacm_pkg::CONV_DSD |-> !cfg.syncEn && // R14
      cfg.tdm == 2'h0)
    else $error("clock sync or slot format active in DSD");
  a_serial_write: assert property (ctlMode == dacm_pkg::CTL_SERIAL3 && sPdnN && !sCsN && // R17
      st_reg.bus == dacm_pkg::B_W3 && clkRise && st_reg.bitCnt == dacm_pkg::FRAME_LAST_BIT &&
      st_reg.isWrite && st_reg.addr == dacm_pkg::ADDR_SYNC |=>
      st_reg.regs[dacm_pkg::IDX_SYNC] == $past({st_reg.shift[6:0], sData}))
    else $error("3-wire write did not land in its register");
endmodule : dacm_control
`default_nettype wire

// *** core/dacm_pkg.sv ***
package dacm_pkg;
  // register byte offsets on the control port
  localparam logic [4:0] ADDR_CLOCK_FORMAT = 5'h00;
  localparam logic [4:0] ADDR_MUTE_EMPH = 5'h01;
  localparam logic [4:0] ADDR_CONV_SELECT = 5'h02;
  localparam logic [4:0] ADDR_LEFT_ATT = 5'h03;
  localparam logic [4:0] ADDR_RIGHT_ATT = 5'h04;
  localparam logic [4:0] ADDR_INVERT = 5'h05;
  localparam logic [4:0] ADDR_PATH_MUTE = 5'h06;
  localparam logic [4:0] ADDR_SYNC = 5'h07;
  localparam logic [4:0] ADDR_ZERO_DET = 5'h08;
  localparam logic [4:0] ADDR_BS_FILTER = 5'h09;
  localparam logic [4:0] ADDR_SLOT_FMT = 5'h0A;
  localparam logic [4:0] ADDR_AUTO_BS = 5'h15;
  localparam logic [4:0] ADDR_PACKED_BS = 5'h16;
  localparam int NUM_REGS = 13;
  // storage index of each register
  localparam logic [3:0] IDX_CLOCK_FORMAT = 4'h0;
  localparam logic [3:0] IDX_MUTE_EMPH = 4'h1;
  localparam logic [3:0] IDX_CONV_SELECT = 4'h2;
  localparam logic [3:0] IDX_LEFT_ATT = 4'h3;
  localparam logic [3:0] IDX_RIGHT_ATT = 4'h4;
  localparam logic [3:0] IDX_INVERT = 4'h5;
  localparam logic [3:0] IDX_PATH_MUTE = 4'h6;
  localparam logic [3:0] IDX_SYNC = 4'h7;
  localparam logic [3:0] IDX_ZERO_DET = 4'h8;
  localparam logic [3:0] IDX_BS_FILTER = 4'h9;
  localparam logic [3:0] IDX_SLOT_FMT = 4'hA;
  localparam logic [3:0] IDX_AUTO_BS = 4'hB;
  localparam logic [3:0] IDX_PACKED_BS = 4'hC;
  // field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int FORMAT_LSB = 1;
  localparam int CLOCK_SET_LSB = 4;
  localparam int AUTO_CLOCK_BIT = 7;
  localparam int SOFT_MUTE_BIT = 0;
  localparam int EMPH_LSB = 1;
  localparam int SHORT_DELAY_BIT = 5;
  localparam int BS_MODE_BIT = 0;
  localparam int BS_CLOCK_BIT = 1;
  localparam int MONO_BIT = 3;
  localparam int LEFT_SRC_BIT = 4;
  localparam int LEFT_INV_BIT = 7;
  localparam int RIGHT_INV_BIT = 6;
  localparam int SUPER_SLOW_BIT = 0;
  localparam int PATH_BYPASS_BIT = 0;
  localparam int FS_MUTE_BIT = 1;
  localparam int SYNC_EN_BIT = 0;
  localparam int ZD_LEFT_BIT = 1;
  localparam int ZD_RIGHT_BIT = 0;
  localparam int BS_FILTER_BIT = 0;
  localparam int TDM_LSB = 0;
  localparam int AUTO_BS_BIT = 0;
  localparam int PACKED_SEL_BIT = 0;
  localparam int AUTO_PACKED_BIT = 1;
  // field codes
  localparam logic [2:0] FMT_MSB32 = 3'h6;
  localparam logic [1:0] CLK_512FS = 2'h2;
  localparam logic [1:0] EMPH_OFF = 2'h1;
  localparam logic [7:0] ATT_0DB = 8'hFF;
  // reset values
  localparam logic [7:0] RST_CLOCK_FORMAT = 8'h2C;
  localparam logic [7:0] RST_MUTE_EMPH = 8'h22;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h01;
  localparam logic [NUM_REGS-1:0][7:0] RST_ALL = {RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
    RST_ZERO, RST_SYNC, RST_ZERO, RST_ZERO, ATT_0DB, ATT_0DB, RST_ZERO, RST_MUTE_EMPH,
    RST_CLOCK_FORMAT};
  // serial framing
  localparam logic [3:0] HDR_LAST_BIT = 4'h7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hF;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam int WRITE_FLAG_BIT = 7;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h11; // arbitrary value
  typedef enum logic [1:0] {CTL_SERIAL3, CTL_I2C, CTL_PIN} dacm_ctl_t;
  typedef enum logic [1:0] {CONV_PCM, CONV_DSD, CONV_DOP} dacm_conv_t;
  typedef enum logic [2:0] {B_IDLE, B_W3, B_DEV, B_REG, B_WDATA, B_RDATA, B_HOLD} dacm_bus_t;
  // function-setting pins used in pin control
  typedef struct packed {
    logic [1:0] clockSet;
    logic [2:0] ifFormat;
    logic [1:0] tdm;
    logic softMute;
  } dacm_pins_t;
  // effective settings handed to the datapath
  typedef struct packed {
    dacm_conv_t conv;
    logic autoClock;
    logic [1:0] clockSet;
    logic bsClock;
    logic [2:0] ifFormat;
    logic [1:0] tdm;
    logic softMute;
    logic [1:0] emphasis;
    logic shortDelay;
    logic superSlow;
    logic bsFilter;
    logic [7:0] attL;
    logic [7:0] attR;
    logic zeroDetL;
    logic zeroDetR;
    logic mono;
    logic leftSrc;
    logic left_invert;
    logic right_invert;
    logic pathBypass;
    logic fsMute;
    logic syncEn;
    logic softResetN;
  } dacm_cfg_t;
endpackage : dacm_pkg

// *** core/dacm_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pins from outside the clock domain
module dacm_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic soft_reset_bit,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // first stage is read only by the second
  logic [W-1:0] meta_reg;
  logic [W-1:0] stable_reg;

  // both stages clear to zero under reset
  always_ff @(posedge clk or negedge soft_reset_bit) begin
    if (!soft_reset_bit) begin
      meta_reg <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg <= din;
      stable_reg <= meta_reg;
    end
  end

  assign dout = stable_reg;
endmodule : dacm_sync2
`default_nettype wire

// *** verification/dac_control_mode_and_function_map_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dac_control_mode_and_function_map_tb;
  logic clk = 1'b0;
  logic soft_reset_bit = 1'b0;
  logic power_down_pin = 1'b0;
  logic busSel = 1'b0;
  logic ctlSel = 1'b0;
  logic dsdIn = 1'b0;
  logic dopIn = 1'b0;
  logic [7:0] lfsr = 8'h30;
  logic [7:0] rd;
  logic [8:0] got9;
  dacm_pkg::dacm_pins_t pins = '0;
  logic sclk, sdo, csN, dOut, dOe, dataWire;
  dacm_pkg::dacm_ctl_t mode;
  dacm_pkg::dacm_cfg_t cfg;
  int fail_count = 0;
  int n_checks = 0;
  int mdl[int]; // behavioural register map
  always #2.5 clk = ~clk;
  // device owns the shared pin while its enable is high
  assign dataWire = dOe ? dOut : sdo;
  dacm_control u_dut (.clk(clk), .soft_reset_bit(soft_reset_bit), .powerDownPinN(power_down_pin), .busSelectPin(busSel),
    .controlSelectPin(ctlSel), .ctlClk(sclk), .ctlDataIn(dataWire), .ctlSelectN(csN),
    .fnPins(pins), .detectDsd(dsdIn), .detectDop(dopIn), .ctlDataOut(dOut),
    .ctlDataOe(dOe), .ctlMode(mode), .cfg(cfg));
  dacm_host_model u_host (.clk(clk), .dataWire(dataWire), .sclk(sclk), .sdo(sdo), .csN(csN));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  task automatic chk_f(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk_f
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.xfer({3'h4, a, d}, rd);
    if (mdl.exists(a)) mdl[a] = d;
  endtask : wr
  task automatic rd_chk(input logic [4:0] a);
    u_host.xfer({3'h0, a, 8'h00}, rd);
    chk_f("reg", mdl.exists(a) ? 8'(mdl[a]) : 8'h00, rd);
  endtask : rd_chk
  // one I2C byte out; the device must pull the ninth bit low
  task automatic i2c_wr(input logic [7:0] d);
    logic [8:0] got;
    u_host.i2c_byte({d, 1'b1}, got);
    chk_f("ack", 8'h00, 8'(got[0]));
  endtask : i2c_wr
  // straps change only inside power-down, which also restores defaults
  task automatic pwr_down(input logic b, input logic c);
    power_down_pin = 1'b0;
    repeat (6) @(posedge clk);
    #1 busSel = b;
    ctlSel = c;
    lfsr = nxt(lfsr);
    pins = lfsr;
    repeat (6) @(posedge clk);
    #1 power_down_pin = 1'b1;
    repeat (6) @(posedge clk);
    #1 mdl = '{0: 8'h2C, 1: 8'h22, 2: 8'h00, 3: 8'hFF, 4: 8'hFF, 5: 8'h00, 6: 8'h00,
      7: 8'h01, 8: 8'h00, 9: 8'h00, 10: 8'h00, 21: 8'h00, 22: 8'h00};
  endtask : pwr_down
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // watchdog well past the roughly 50 us of traffic
  initial begin
    #300us;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 soft_reset_bit = 1'b1;
    pwr_down(1'b0, 1'b0);
    chk_f("mode", 8'(dacm_pkg::CTL_SERIAL3), 8'(mode));
    foreach (mdl[a]) rd_chk(5'(a));
    rd_chk(5'h1F);
    chk_f("clockSet", 8'h02, 8'(cfg.clockSet));
    chk_f("bsClock", 8'h00, 8'(cfg.bsClock));
    chk_f("ifFormat", 8'h06, 8'(cfg.ifFormat));
    chk_f("attL", 8'hFF, cfg.attL);
    chk_f("syncEn", 8'h01, 8'(cfg.syncEn));
    $display("test defaults done");
    // soft reset bit held at zero so mode writes are legal
    foreach (mdl[a]) begin
      lfsr = nxt(lfsr);
      wr(5'(a), a == 0 ? lfsr & 8'hFE : lfsr);
    end
    wr(5'h1F, 8'hA5);
    foreach (mdl[a]) rd_chk(5'(a));
    $display("test readback done");
    pwr_down(1'b0, 1'b0);
    wr(5'h0A, 8'h03);
    wr(5'h06, 8'h02);
    chk_f("tdm", 8'h03, 8'(cfg.tdm));
    chk_f("fsMute", 8'h00, 8'(cfg.fsMute));
    wr(5'h02, 8'h09);
    chk_f("conv", 8'(dacm_pkg::CONV_DSD), 8'(cfg.conv));
    chk_f("tdm", 8'h00, 8'(cfg.tdm));
    chk_f("fsMute", 8'h01, 8'(cfg.fsMute));
    chk_f("mono", 8'h01, 8'(cfg.mono));
    wr(5'h16, 8'h01);
    chk_f("conv", 8'(dacm_pkg::CONV_DOP), 8'(cfg.conv));
    wr(5'h16, 8'h02);
    chk_f("conv", 8'(dacm_pkg::CONV_PCM), 8'(cfg.conv));
    dopIn = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk_f("conv", 8'(dacm_pkg::CONV_DOP), 8'(cfg.conv));
    dopIn = 1'b0;
    wr(5'h16, 8'h00);
    wr(5'h15, 8'h01);
    chk_f("conv", 8'(dacm_pkg::CONV_PCM), 8'(cfg.conv));
    dsdIn = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk_f("conv", 8'(dacm_pkg::CONV_DSD), 8'(cfg.conv));
    $display("test conversion done");
    pwr_down(1'b1, 1'b1);
    chk_f("mode", 8'(dacm_pkg::CTL_PIN), 8'(mode));
    chk_f("ifFormat", 8'(pins.ifFormat), 8'(cfg.ifFormat));
    chk_f("tdm", 8'(pins.tdm), 8'(cfg.tdm));
    chk_f("clockSet", 8'(pins.clockSet), 8'(cfg.clockSet));
    chk_f("softMute", 8'(pins.softMute), 8'(cfg.softMute));
    chk_f("conv", 8'(dacm_pkg::CONV_PCM), 8'(cfg.conv));
    pwr_down(1'b1, 1'b0);
    chk_f("mode", 8'(dacm_pkg::CTL_I2C), 8'(mode));
    $display("test straps done");
    // I2C: burst write 03h/04h, then set offset, repeated start, read both
    lfsr = nxt(lfsr);
    mdl[3] = lfsr;
    mdl[4] = nxt(lfsr);
    u_host.i2c_edge(1'b1);
    i2c_wr({dacm_pkg::I2C_DEV_ADDR, 1'b0});
    i2c_wr(8'h03);
    i2c_wr(lfsr);
    i2c_wr(nxt(lfsr));
    u_host.i2c_edge(1'b1);
    i2c_wr({dacm_pkg::I2C_DEV_ADDR, 1'b0});
    i2c_wr(8'h03);
    u_host.i2c_edge(1'b1);
    i2c_wr({dacm_pkg::I2C_DEV_ADDR, 1'b1});
    u_host.i2c_byte({8'hFF, 1'b0}, got9);
    chk_f("reg", 8'(mdl[3]), got9[8:1]);
    u_host.i2c_byte({8'hFF, 1'b1}, got9);
    chk_f("reg", 8'(mdl[4]), got9[8:1]);
    u_host.i2c_edge(1'b0);
    chk_f("attR", 8'(mdl[4]), cfg.attR);
    $display("test i2c done");
    wrap_up();
  end
endmodule : dac_control_mode_and_function_map_tb
`default_nettype wire

// *** verification/dacm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host end of the 3-wire and I2C control ports
module dacm_host_model (
  input wire logic clk,
  input wire logic dataWire,
  output logic sclk,
  output logic sdo,
  output logic csN
);
  // serial clock stands low outside frames
  initial begin
    sclk = 1'b0;
    sdo = 1'b0;
    csN = 1'b1;
  end
  // one frame: header then data, MSB first; halves of 5 clk beat the 3-flop path
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk) #1 csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      // released line toggles so a stale copy never passes
      sdo = (i < 8 && !frame[15]) ? ~sdo : frame[i];
      repeat (5) @(posedge clk);
      #1 if (i < 8) rd[i] = dataWire;
      sclk = 1'b1;
      repeat (5) @(posedge clk);
      #1;
    end
    csN = 1'b1;
    sclk = 1'b0;
    sdo = ~sdo;
    repeat (5) @(posedge clk);
    #1;
  endtask : xfer
  // I2C: nine bits a call, SDA moves only mid-way through SCL low
  task automatic i2c_byte(input logic [8:0] bits, output logic [8:0] got);
    for (int i = 8; i >= 0; i--) begin
      sclk = 1'b0;
      repeat (5) @(posedge clk);
      #1 sdo = bits[i];
      repeat (5) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (5) @(posedge clk);
      #1 got[i] = dataWire;
      repeat (5) @(posedge clk);
      #1;
    end
  endtask : i2c_byte
  // SDA moves while SCL high: from 1 a start, from 0 a stop
  task automatic i2c_edge(input logic from);
    sclk = 1'b0;
    repeat (5) @(posedge clk);
    #1 sdo = from;
    repeat (5) @(posedge clk);
    #1 sclk = 1'b1;
    repeat (5) @(posedge clk);
    #1 sdo = ~from;
    repeat (5) @(posedge clk);
    #1;
  endtask : i2c_edge
endmodule : dacm_host_model
`default_nettype wire
